// [cps_pkg.sv]
// ****************************************************************
// timing and count constants for the protection sequencer
// ****************************************************************
package cps_pkg;
  // system clock
  localparam int unsigned MCLK_PERIOD_NS   = 25;
  localparam int unsigned MCLK_MHZ         = 40;
  // timer capacitor tick period with the nominal capacitor fitted
  localparam int unsigned CT_TICK_US       = 250;
  // timer-derived periods, as printed for the nominal capacitor
  localparam int unsigned SS_TIME_US       = 10000;
  localparam int unsigned OLP_TIME_US      = 64000;
  localparam int unsigned PFC_OFF_TIME_US  = 1000000;
  localparam int unsigned PFC_OFF_LONG_US  = 8000000;
  localparam logic [15:0] SS_TICKS         = 16'(SS_TIME_US / CT_TICK_US);
  localparam logic [15:0] OLP_TICKS        = 16'(OLP_TIME_US / CT_TICK_US);
  localparam logic [15:0] PFC_OFF_TICKS    = 16'(PFC_OFF_TIME_US / CT_TICK_US);
  localparam logic [15:0] PFC_OFF_LONG_TK  = 16'(PFC_OFF_LONG_US / CT_TICK_US);
  // short-circuit debounce, counted on the system clock
  localparam int unsigned OUTPUT_SHORT_PROTECTION_TIME_US     = 16000;
  localparam int unsigned OUTPUT_SHORT_PROTECTION_CYC_DEF     = OUTPUT_SHORT_PROTECTION_TIME_US * MCLK_MHZ;
  // aux overvoltage sampling delay after gate turn-off (rounded up)
  localparam int unsigned AUX_BLANK_NS     = 3000;
  localparam logic [7:0]  AUX_BLANK_CYC    =
    8'((AUX_BLANK_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS);
  // consecutive aux overvoltage cycles to trip, turn-off crossings to release
  localparam logic [2:0]  AUX_OV_TRIP      = 3'h4;
  localparam logic [2:0]  OLP_UV_COUNT     = 3'h4;
  // reset values
  localparam logic        FAULT_RST        = 1'b0;
endpackage : cps_pkg

// [cps_protection_sequencer.sv]
`timescale 1ns/1ps
module cps_protection_sequencer
  import cps_pkg::*;
#(
  parameter bit          OLP_LATCH   = 1'b0,
  parameter bit          OVP_LATCH   = 1'b0,
  parameter bit          EXT_LATCH   = 1'b1,
  parameter bit          PFC_LONG    = 1'b0,
  parameter int unsigned OUTPUT_SHORT_PROTECTION_CYC    = OUTPUT_SHORT_PROTECTION_CYC_DEF
) (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic ct_tick_pin,
  input  wire logic supply_on_cmp,
  input  wire logic supply_low_cmp,
  input  wire logic supply_ov_cmp,
  input  wire logic fb_overload_cmp,
  input  wire logic fb_pwm_off_cmp,
  input  wire logic aux_zero_cmp,
  input  wire logic aux_ov_cmp,
  input  wire logic chip_hot_cmp,
  input  wire logic thermistor_low_cmp,
  input  wire logic pfc_light_load_cmp,
  output logic      flyback_gate_q,
  output logic      pfc_gate_en_q,
  output logic      softstart_q,
  output logic      olp_q,
  output logic      output_short_protection_q,
  output logic      ovp_q,
  output logic      ext_q,
  output logic      otp_q
);

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  localparam int NSYNC = 11;
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] sync1_q;
  logic [NSYNC-1:0] sync2_q;
  assign raw_in = {ct_tick_pin, supply_on_cmp, supply_low_cmp, supply_ov_cmp,
                   fb_overload_cmp, fb_pwm_off_cmp, aux_zero_cmp, aux_ov_cmp,
                   chip_hot_cmp, thermistor_low_cmp, pfc_light_load_cmp};

  // two flops per comparator; first stage feeds only the second
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge mclk) begin
        if (rst) begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
        end else begin
          sync1_q[gi] <= raw_in[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate

  logic ct_s, supply_ok_s, low10_s, sup_ov_s, fb_ovl_s, pwm_off_s;
  logic zcd_s, aux_ov_s, hot_s, therm_s, light_s;
  assign {ct_s, supply_ok_s, low10_s, sup_ov_s, fb_ovl_s, pwm_off_s,
          zcd_s, aux_ov_s, hot_s, therm_s, light_s} = sync2_q;

  // ****************************************************************
  // edge detection
  // ****************************************************************
  logic ct_prev_q, sup_prev_q, zcd_prev_q, gate_prev_q;
  logic ct_tick, supply_rise, supply_fall, zcd_fall, gate_fall;

  // previous values for edges
  always_ff @(posedge mclk) begin
    if (rst) begin
      ct_prev_q   <= 1'b0;
      sup_prev_q  <= 1'b0;
      zcd_prev_q  <= 1'b0;
      gate_prev_q <= 1'b0;
    end else begin
      ct_prev_q   <= ct_s;
      sup_prev_q  <= supply_ok_s;
      zcd_prev_q  <= zcd_s;
      gate_prev_q <= flyback_gate_q;
    end
  end

  assign ct_tick     = ct_s && !ct_prev_q;
  assign supply_rise = supply_ok_s && !sup_prev_q;       // turn-on crossing
  assign supply_fall = !supply_ok_s && sup_prev_q;       // turn-off crossing
  assign zcd_fall    = !zcd_s && zcd_prev_q;
  assign gate_fall   = gate_prev_q && !flyback_gate_q;

  // ****************************************************************
  // overload: timer debounce and turn-off crossing divider
  // ****************************************************************
  logic [15:0] olp_cnt_q;
  logic [2:0]  olp_uv_q;
  logic        olp_set;
  assign olp_set = fb_ovl_s && ct_tick && (olp_cnt_q >= OLP_TICKS - 16'h0001);

  // debounce counts timer ticks while feedback sits at the overload level
  always_ff @(posedge mclk) begin
    if (rst || !fb_ovl_s || olp_q) begin
      olp_cnt_q <= 16'h0000;
    end else if (ct_tick && olp_cnt_q != 16'hFFFF) begin
      olp_cnt_q <= olp_cnt_q + 16'h0001;
    end
  end

  // count turn-off crossings only while tripped; saturates at release
  always_ff @(posedge mclk) begin
    if (rst || !olp_q) begin
      olp_uv_q <= 3'h0;
    end else if (supply_fall && olp_uv_q < OLP_UV_COUNT) begin
      olp_uv_q <= olp_uv_q + 3'h1;
    end
  end

  // set wins over the release at turn-on
  always_ff @(posedge mclk) begin
    if (rst) begin
      olp_q <= FAULT_RST;
    end else if (olp_set) begin
      olp_q <= 1'b1;
    end else if (!OLP_LATCH && supply_rise && olp_uv_q == OLP_UV_COUNT) begin
      olp_q <= 1'b0;
    end
  end

  // ****************************************************************
  // output short: fast debounce on the system clock
  // ****************************************************************
  logic [31:0] output_short_protection_cnt_q;
  logic        output_short_protection_cond;
  assign output_short_protection_cond = fb_ovl_s && low10_s;

  // count only while overload and low supply coincide
  always_ff @(posedge mclk) begin
    if (rst || !output_short_protection_cond || output_short_protection_q) begin
      output_short_protection_cnt_q <= 32'h0000_0000;
    end else if (output_short_protection_cnt_q != 32'(OUTPUT_SHORT_PROTECTION_CYC)) begin
      output_short_protection_cnt_q <= output_short_protection_cnt_q + 32'h0000_0001;
    end
  end

  // auto-recovery: released at the next turn-on unless still set
  always_ff @(posedge mclk) begin
    if (rst) begin
      output_short_protection_q <= FAULT_RST;
    end else if (output_short_protection_cond && output_short_protection_cnt_q == 32'(OUTPUT_SHORT_PROTECTION_CYC)) begin
      output_short_protection_q <= 1'b1;
    end else if (supply_rise) begin
      output_short_protection_q <= 1'b0;
    end
  end

  // ****************************************************************
  // aux winding overvoltage sampling
  // ****************************************************************
  logic [7:0] blank_q;
  logic [2:0] aux_cnt_q;
  logic       aux_sample;
  assign aux_sample = (blank_q == 8'h01);

  // blank leakage ringing after each turn-off, then sample once
  always_ff @(posedge mclk) begin
    if (rst) begin
      blank_q <= 8'h00;
    end else if (gate_fall) begin
      blank_q <= AUX_BLANK_CYC;
    end else if (blank_q != 8'h00) begin
      blank_q <= blank_q - 8'h01;
    end
  end

  // consecutive event counter; a quiet cycle or a trip starts it again,
  // else a saturated count would never re-trip after auto-recovery
  always_ff @(posedge mclk) begin
    if (rst || ovp_q) begin
      aux_cnt_q <= 3'h0;
    end else if (aux_sample && !aux_ov_s) begin
      aux_cnt_q <= 3'h0;
    end else if (aux_sample && aux_cnt_q < AUX_OV_TRIP) begin
      aux_cnt_q <= aux_cnt_q + 3'h1;
    end
  end

  // supply and aux overvoltage share one policy; supply trips at once
  always_ff @(posedge mclk) begin
    if (rst) begin
      ovp_q <= FAULT_RST;
    end else if (sup_ov_s || (aux_sample && aux_ov_s &&
                 aux_cnt_q == AUX_OV_TRIP - 3'h1)) begin
      ovp_q <= 1'b1;
    end else if (!OVP_LATCH && supply_rise) begin
      ovp_q <= 1'b0;
    end
  end

  // ****************************************************************
  // thermistor latch and chip overtemperature
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (rst) begin
      ext_q <= FAULT_RST;
    end else if (therm_s) begin
      ext_q <= 1'b1;
    end else if (!EXT_LATCH && supply_rise) begin
      ext_q <= 1'b0;
    end
  end

  // comparator carries the hysteresis, so follow it directly
  always_ff @(posedge mclk) begin
    if (rst) begin
      otp_q <= FAULT_RST;
    end else begin
      otp_q <= hot_s;
    end
  end

  // ****************************************************************
  // gate drive
  // ****************************************************************
  logic any_fault, gate_allow, allow_prev_q;
  assign any_fault  = olp_q || output_short_protection_q || ovp_q || ext_q || otp_q;
  assign gate_allow = supply_ok_s && !any_fault;

  always_ff @(posedge mclk) begin
    if (rst) begin
      allow_prev_q <= 1'b0;
    end else begin
      allow_prev_q <= gate_allow;
    end
  end

  // first pulse on enable gives the turn-on burst when a fault persists
  always_ff @(posedge mclk) begin
    if (rst || !gate_allow) begin
      flyback_gate_q <= 1'b0;
    end else if (flyback_gate_q && pwm_off_s) begin
      flyback_gate_q <= 1'b0;
    end else if (!flyback_gate_q && (zcd_fall || !allow_prev_q)) begin
      flyback_gate_q <= 1'b1;
    end
  end

  // soft-start window after each turn-on
  logic [15:0] ss_cnt_q;
  always_ff @(posedge mclk) begin
    if (rst || supply_rise) begin
      ss_cnt_q    <= 16'h0000;
      softstart_q <= 1'b1;
    end else if (ct_tick && softstart_q) begin
      ss_cnt_q    <= ss_cnt_q + 16'h0001;
      softstart_q <= (ss_cnt_q < SS_TICKS - 16'h0001);
    end
  end

  // pfc light-load turn-off debounce; resumes at once when load returns
  logic [15:0] pfc_cnt_q;
  logic [15:0] pfc_lim;
  assign pfc_lim = PFC_LONG ? PFC_OFF_LONG_TK : PFC_OFF_TICKS;
  always_ff @(posedge mclk) begin
    if (rst || !light_s) begin
      pfc_cnt_q <= 16'h0000;
    end else if (ct_tick && pfc_cnt_q != pfc_lim) begin
      pfc_cnt_q <= pfc_cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      pfc_gate_en_q <= 1'b0;
    end else begin
      pfc_gate_en_q <= gate_allow && !(light_s && pfc_cnt_q == pfc_lim);
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  property p_fault_gate_off;
    any_fault |=> !flyback_gate_q;
  endproperty
  a_fault_gate_off: assert property (p_fault_gate_off) else $error("gate on during fault");

  property p_olp_trip;
    olp_set |=> olp_q ##1 !flyback_gate_q;
  endproperty
  a_olp_trip: assert property (p_olp_trip) else $error("overload did not trip");

  property p_olp_hold;
    olp_q && (olp_uv_q != OLP_UV_COUNT || OLP_LATCH) |=> olp_q;
  endproperty
  a_olp_hold: assert property (p_olp_hold) else $error("overload released early");

  property p_ovp_now;
    sup_ov_s |=> ovp_q ##1 !flyback_gate_q;
  endproperty
  a_ovp_now: assert property (p_ovp_now) else $error("supply ovp late");

  property p_aux_clear;
    aux_sample && !aux_ov_s |=> aux_cnt_q == 3'h0;
  endproperty
  a_aux_clear: assert property (p_aux_clear) else $error("aux counter kept");

  property p_aux_trip;
    aux_sample && aux_ov_s && aux_cnt_q == 3'h3 |=> ovp_q;
  endproperty
  a_aux_trip: assert property (p_aux_trip) else $error("aux ovp missed");

  property p_aux_blank;
    gate_fall |=> !aux_sample [*8];
  endproperty
  a_aux_blank: assert property (p_aux_blank) else $error("aux sampled in blanking");

  property p_ext_latch;
    ext_q && EXT_LATCH |=> ext_q;
  endproperty
  a_ext_latch: assert property (p_ext_latch) else $error("thermistor latch lost");

  property p_ext_set;
    therm_s |=> ext_q;
  endproperty
  a_ext_set: assert property (p_ext_set) else $error("thermistor trip missed");

  property p_zcd_on;
    zcd_fall && gate_allow && !flyback_gate_q && !pwm_off_s |=> flyback_gate_q;
  endproperty
  a_zcd_on: assert property (p_zcd_on) else $error("valley turn-on missed");

  property p_output_short_protection;
    output_short_protection_cond && output_short_protection_cnt_q == 32'(OUTPUT_SHORT_PROTECTION_CYC) |=> output_short_protection_q;
  endproperty
  a_output_short_protection: assert property (p_output_short_protection) else $error("short protection missed");

  c_olp_trip:  cover property (olp_set);
  c_aux_trip:  cover property (aux_sample && aux_ov_s && aux_cnt_q == 3'h3);
  c_ext_latch: cover property (therm_s ##1 ext_q);
  c_recover:   cover property (supply_rise && olp_q && olp_uv_q == OLP_UV_COUNT);

endmodule : cps_protection_sequencer

// [cps_far_model.sv]
`timescale 1ns/1ps
// ****************************************
// far side: timer cap, sense and aux winding
// ****************************************
module cps_far_model (
  input  wire logic       mclk,
  input  wire logic       flyback_gate_q,
  input  wire logic [7:0] ov_pat,
  input  wire logic       ring_only,
  output logic            ct_tick_pin,
  output logic            fb_pwm_off_cmp,
  output logic            aux_zero_cmp,
  output logic            aux_ov_cmp
);
  logic [2:0] tick_q = 3'h0;
  logic [8:0] on_q   = 9'h000;
  logic [8:0] off_q  = 9'h1FF;
  logic [2:0] idx_q  = 3'h0;
  logic       gate_q = 1'b0;
  initial {ct_tick_pin, fb_pwm_off_cmp, aux_zero_cmp, aux_ov_cmp} = 4'h0;
  // tick every 8 clocks, slow enough to pass the synchroniser
  always @(posedge mclk) begin
    tick_q <= tick_q + 3'h1;
    ct_tick_pin <= tick_q[2];
    gate_q <= flyback_gate_q;
  end
  // peak current reached 40 clocks into each on-time
  always @(posedge mclk) begin
    on_q <= flyback_gate_q ? on_q + 9'h001 : 9'h000;
    fb_pwm_off_cmp <= flyback_gate_q && (on_q >= 9'h028);
  end
  // demagnetising lasts 200 clocks, then the winding falls to a valley
  always @(posedge mclk) begin
    if (flyback_gate_q) begin
      off_q <= 9'h000;
    end else if (off_q != 9'h1FF) begin
      off_q <= off_q + 9'h001;
    end
    aux_zero_cmp <= !flyback_gate_q && (off_q < 9'h0C8);
  end
  // per-cycle overvoltage from the pattern; ring mode is only a short spike
  always @(posedge mclk) begin
    if (gate_q && !flyback_gate_q) begin
      idx_q <= idx_q + 3'h1;
    end
    aux_ov_cmp <= !flyback_gate_q && ov_pat[idx_q] &&
      (off_q < (ring_only ? 9'h03C : 9'h0C8));
  end
endmodule : cps_far_model

// [tb_top.sv]
`timescale 1ns/1ps
// ****************************************
// bench for the protection sequencer
// ****************************************
module tb_top;
  import cps_pkg::*;
  localparam int unsigned SIM_OUTPUT_SHORT_PROTECTION = 200;
  logic       mclk               = 1'b0;
  logic       rst                = 1'b1;
  logic       supply_on_cmp      = 1'b1;
  logic       supply_low_cmp     = 1'b0;
  logic       supply_ov_cmp      = 1'b0;
  logic       fb_overload_cmp    = 1'b0;
  logic       chip_hot_cmp       = 1'b0;
  logic       thermistor_low_cmp = 1'b0;
  logic       pfc_light_load_cmp = 1'b0;
  logic [7:0] ov_pat             = 8'h00;
  logic       ring_only          = 1'b0;
  logic       ct_tick_pin, fb_pwm_off_cmp, aux_zero_cmp, aux_ov_cmp;
  logic       flyback_gate_q, pfc_gate_en_q, softstart_q;
  logic       olp_q, output_short_protection_q, ovp_q, ext_q, otp_q;
  logic       lat_gate, lat_olp, lat_ovp, lat_ext;
  int         err_total          = 0;
  int         num_checks         = 0;
  int         gap;

  initial begin
    forever #12.5 mclk = ~mclk;
  end

  cps_protection_sequencer #(.OUTPUT_SHORT_PROTECTION_CYC(SIM_OUTPUT_SHORT_PROTECTION)) uut (
    .mclk, .rst, .ct_tick_pin, .supply_on_cmp, .supply_low_cmp, .supply_ov_cmp,
    .fb_overload_cmp, .fb_pwm_off_cmp, .aux_zero_cmp, .aux_ov_cmp, .chip_hot_cmp,
    .thermistor_low_cmp, .pfc_light_load_cmp, .flyback_gate_q, .pfc_gate_en_q,
    .softstart_q, .olp_q, .output_short_protection_q, .ovp_q, .ext_q, .otp_q
  );
  cps_far_model far (
    .mclk, .flyback_gate_q, .ov_pat, .ring_only, .ct_tick_pin, .fb_pwm_off_cmp,
    .aux_zero_cmp, .aux_ov_cmp
  );
  // copy with overload and overvoltage latched, thermistor auto-recovering, on the same stimulus; its overload, overvoltage and thermistor flags and gate are judged
  cps_protection_sequencer #(
    .OLP_LATCH(1'b1), .OVP_LATCH(1'b1), .EXT_LATCH(1'b0), .PFC_LONG(1'b1),
    .OUTPUT_SHORT_PROTECTION_CYC(SIM_OUTPUT_SHORT_PROTECTION)
  ) uut_latch (
    .mclk, .rst, .ct_tick_pin, .supply_on_cmp, .supply_low_cmp, .supply_ov_cmp,
    .fb_overload_cmp, .fb_pwm_off_cmp, .aux_zero_cmp, .aux_ov_cmp, .chip_hot_cmp,
    .thermistor_low_cmp, .pfc_light_load_cmp, .flyback_gate_q(lat_gate),
    .pfc_gate_en_q(), .softstart_q(), .olp_q(lat_olp), .output_short_protection_q(), .ovp_q(lat_ovp),
    .ext_q(lat_ext), .otp_q()
  );

  task automatic chk(input string what, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask : chk

  // outputs are sampled on the falling edge, away from the update edge
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask : cyc

  // bounded wait, so a stuck gate cannot hang the run
  task automatic wait_gate(input logic lvl);
    gap = 0;
    while (flyback_gate_q !== lvl && gap < 2000) begin
      cyc(1);
      gap++;
    end
  endtask : wait_gate

  // supply drops through turn-off, then climbs back past turn-on
  task automatic supply_cycle();
    @(posedge mclk);
    supply_on_cmp <= 1'b0;
    cyc(20);
    @(posedge mclk);
    supply_on_cmp <= 1'b1;
    cyc(10);
  endtask : supply_cycle

  task automatic do_reset();
    @(posedge mclk);
    rst <= 1'b1;
    cyc(4);
    @(posedge mclk);
    rst <= 1'b0;
    cyc(602);
  endtask : do_reset

  task automatic done(input string name);
    $display("end of test %s", name);
  endtask : done

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize

  initial begin
    cyc(4);
    chk("softstart_q", 1'b1, softstart_q);
    chk("fault_flags", 1'b0, |{olp_q, output_short_protection_q, ovp_q, ext_q, otp_q});
    @(posedge mclk);
    rst <= 1'b0;
    done("reset");
    // gate restarts only once the aux winding has fallen to a valley
    cyc(600);
    wait_gate(1'b1);
    wait_gate(1'b0);
    wait_gate(1'b1);
    chk("valley_gap", 1'b1, gap >= 200 && gap <= 215);
    done("valley");
    @(posedge mclk);
    supply_ov_cmp <= 1'b1;
    cyc(6);
    chk("ovp_q", 1'b1, ovp_q);
    chk("flyback_gate_q", 1'b0, flyback_gate_q);
    @(posedge mclk);
    supply_ov_cmp <= 1'b0;
    cyc(10);
    chk("ovp_q", 1'b1, ovp_q);
    supply_cycle();
    chk("ovp_q", 1'b0, ovp_q);
    chk("softstart_q", 1'b1, softstart_q);
    chk("lat_ovp", 1'b1, lat_ovp);
    chk("lat_gate", 1'b0, lat_gate);
    wait_gate(1'b1);
    chk("flyback_gate_q", 1'b1, flyback_gate_q);
    done("supply_ov");
    @(posedge mclk);
    chip_hot_cmp <= 1'b1;
    cyc(6);
    chk("otp_q", 1'b1, otp_q);
    chk("drives", 1'b0, flyback_gate_q | pfc_gate_en_q);
    @(posedge mclk);
    chip_hot_cmp <= 1'b0;
    cyc(6);
    chk("otp_q", 1'b0, otp_q);
    done("overtemp");
    @(posedge mclk);
    thermistor_low_cmp <= 1'b1;
    cyc(6);
    chk("ext_q", 1'b1, ext_q);
    chk("drives", 1'b0, flyback_gate_q | pfc_gate_en_q);
    @(posedge mclk);
    thermistor_low_cmp <= 1'b0;
    supply_cycle();
    chk("ext_q", 1'b1, ext_q);
    chk("lat_ext", 1'b0, lat_ext);
    chk("flyback_gate_q", 1'b0, flyback_gate_q);
    do_reset();
    chk("ext_q", 1'b0, ext_q);
    chk("lat_ovp", 1'b0, lat_ovp);
    chk("softstart_q", 1'b0, softstart_q);
    chk("pfc_gate_en_q", 1'b1, pfc_gate_en_q);
    done("ext_latch");
    // 256 ticks of 8 clocks: just short of it, then past it
    @(posedge mclk);
    fb_overload_cmp <= 1'b1;
    cyc(1990);
    chk("olp_q", 1'b0, olp_q);
    chk("output_short_protection_q", 1'b0, output_short_protection_q);
    cyc(200);
    chk("olp_q", 1'b1, olp_q);
    chk("flyback_gate_q", 1'b0, flyback_gate_q);
    @(posedge mclk);
    fb_overload_cmp <= 1'b0;
    repeat (3) supply_cycle();
    chk("olp_q", 1'b1, olp_q);
    supply_cycle();
    chk("olp_q", 1'b0, olp_q);
    chk("lat_olp", 1'b1, lat_olp);
    done("overload");
    @(posedge mclk);
    supply_low_cmp <= 1'b1;
    fb_overload_cmp <= 1'b1;
    cyc(150);
    chk("output_short_protection_q", 1'b0, output_short_protection_q);
    cyc(80);
    chk("output_short_protection_q", 1'b1, output_short_protection_q);
    chk("flyback_gate_q", 1'b0, flyback_gate_q);
    @(posedge mclk);
    supply_low_cmp <= 1'b0;
    fb_overload_cmp <= 1'b0;
    do_reset();
    done("short");
    // 4000 ticks of 8 clocks: light load just short of the debounce, then past it
    @(posedge mclk);
    pfc_light_load_cmp <= 1'b1;
    cyc(31900);
    chk("pfc_gate_en_q", 1'b1, pfc_gate_en_q);
    cyc(200);
    chk("pfc_gate_en_q", 1'b0, pfc_gate_en_q);
    @(posedge mclk);
    pfc_light_load_cmp <= 1'b0;
    cyc(6);
    chk("pfc_gate_en_q", 1'b1, pfc_gate_en_q);
    done("pfc_off");
    // leakage spikes alone, then runs of three, must not trip
    @(posedge mclk);
    ov_pat <= 8'hFF;
    ring_only <= 1'b1;
    cyc(2000);
    chk("ovp_q", 1'b0, ovp_q);
    @(posedge mclk);
    ring_only <= 1'b0;
    ov_pat <= 8'h77;
    cyc(2500);
    chk("ovp_q", 1'b0, ovp_q);
    @(posedge mclk);
    ov_pat <= 8'hFF;
    cyc(1400);
    chk("ovp_q", 1'b1, ovp_q);
    chk("flyback_gate_q", 1'b0, flyback_gate_q);
    done("aux_ov");
    summarize();
  end

  // the tests need about 45000 clocks; 80000 means a hang
  initial begin
    #2000000;
    err_total++;
    $display("watchdog expired");
    summarize();
  end
endmodule : tb_top
